// ### design/flash_status_write_protect.v
// Status register, write latch and block protection of a serial flash
// Contract
// R1: Eight-bit status: busy, latch, four protect bits, quad enable, lock; all reset zero.
// R2: Busy flag is read-only and high during program, erase or register write.
// R3: While busy only reads, resets and suspend during array work are accepted.
// R4: Finished operation clears busy regardless of outcome; instructions accepted again.
// R5: Latch set and cleared by its instructions, cleared when a write completes.
// R6: Write-status never alters the latch bit.
// R7: Page programs need the latch set; otherwise inhibited.
// R8: All erases need the latch set; otherwise inhibited.
// R9: Status, function, persistent parameter, info row and autoboot writes need the latch.
// R10: Volatile read-parameter sets need no latch.
// R11: Protect, quad and lock bits are persistent, changed only by write-status.
// R12: Read-status returns the whole status register.
// R13: Level n of 1..7 protects 2^(n-1) blocks from top or bottom.
// R14: Level zero protects nothing; top bit set protects all; protected targets inhibited.
// R15: Chip erase ignored unless the protect level is zero.
// R16: Lock set with protect pin low makes write-status ignored.
// R17: Lock clear, or protect pin high, lets write-status change the register.
// R18: Quad disabled: extra pins are protect and hold/reset; enabled: data lines.
// R19: Bottom selection may go from top to bottom only, never back.
// R20: Input sampled on rising serial clock, output driven after falling edge.
// R21: Read-status 05h, set latch 06h, clear latch 04h.
// R22: Gated instruction with latch clear changes nothing and leaves busy low.
`timescale 1ns/1ps
`include "flash_status_consts.vh"

module flash_status_write_protect (
    input  wire        ref_clk,
    input  wire        arst_n,
    input  wire        sclk,
    input  wire        csN,
    input  wire        si,
    input  wire        io2In,
    input  wire        io3In,
    input  wire        resetPinSelect,
    input  wire        opDone,
    input  wire        coreIo2Out,
    input  wire        coreIo2Oe,
    input  wire        coreIo3Out,
    input  wire        coreIo3Oe,
    output reg         soOut,
    output reg         soOe,
    output reg         io2Out,
    output reg         io2Oe,
    output reg         io3Out,
    output reg         io3Oe,
    output reg         opStart,
    output reg  [7:0]  opCode,
    output reg  [23:0] opAddr,
    output reg         suspendReq,
    output reg         abortReq,
    output reg         quadMode,
    output reg         holdActive,
    output reg         protectFromBottom
);
    localparam [1:0] ST_IDLE   = 2'b00;
    localparam [1:0] ST_SHIFT  = 2'b01;
    localparam [1:0] ST_STATUS = 2'b10;
    localparam [1:0] ST_SKIP   = 2'b11;

    // Array operations: program, erase and info row work
    function isArrayOp;
        input [7:0] opc;
        begin
            isArrayOp = (opc == `OPC_PAGE_PROG) || (opc == `OPC_QPROG_A)
                || (opc == `OPC_QPROG_B) || (opc == `OPC_SECT_ERASE_A)
                || (opc == `OPC_SECT_ERASE_B) || (opc == `OPC_ERASE_32K)
                || (opc == `OPC_ERASE_64K) || (opc == `OPC_CHIP_ERASE_A)
                || (opc == `OPC_CHIP_ERASE_B) || (opc == `OPC_INFO_ERASE)
                || (opc == `OPC_INFO_PROG);
        end
    endfunction

    // Instructions that stay accepted while busy
    function allowedBusy;
        input [7:0] opc;
        input       arrayBusy;
        begin
            allowedBusy = (opc == `OPC_READ_STATUS) || (opc == `OPC_READ_FUNC)
                || (opc == `OPC_READ_EXTREG) || (opc == `OPC_RESET_ENA)
                || (opc == `OPC_RESET_GO)
                || (arrayBusy && ((opc == `OPC_SUSPEND_A) || (opc == `OPC_SUSPEND_B)));
        end
    endfunction

    // Status bits
    reg        busy;
    reg        write_enable_latch;
    reg [3:0]  protectLevel;
    reg        quadEnable;
    reg        statusLock;
    reg        busyArray;

    // Frame engine
    reg [1:0]  state;
    reg        sclkPrev;
    reg        csPrev;
    reg [7:0]  bitCnt;
    reg [7:0]  shiftIn;
    reg [7:0]  opReg;
    reg [7:0]  dataReg;
    reg [23:0] addrReg;
    reg [7:0]  statusShift;
    reg [2:0]  outCnt;
    reg        resetArmed;
    reg        nvStart;

    wire       sclkRise = sclk & ~sclkPrev;   // R20
    wire       sclkFall = ~sclk & sclkPrev;   // R20
    wire       csRise   = csN & ~csPrev;
    wire [7:0] opNow    = {shiftIn[6:0], si};
    wire [7:0] statusNow = {statusLock, quadEnable, protectLevel, write_enable_latch, busy}; // R1 R12

    // Protect pin only exists while quad is off; treat it as high otherwise
    wire       wpLevel  = quadEnable ? 1'b1 : io2In;                // R18
    wire       hwLocked = statusLock & ~wpLevel;                    // R16 R17
    wire       pinReset = ~quadEnable & resetPinSelect & ~io3In;    // R18
    wire       pinHold  = ~quadEnable & ~resetPinSelect & ~io3In;   // R18
    wire       nvDone;
    wire       targetProtected;

    protect_decoder uDecoder (
        .protectLevel   (protectLevel),
        .fromBottom     (protectFromBottom),
        .blockNum       (addrReg[`ADDR_BLK_MSB:`ADDR_BLK_LSB]),
        .blockProtected (targetProtected)
    );

    nv_write_timer uTimer (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .start   (nvStart),
        .abort   (abortReq),
        .done    (nvDone)
    );

    // Pin routing registered so every pin output comes from a flip-flop
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            io2Out     <= 1'b0;
            io2Oe      <= 1'b0;
            io3Out     <= 1'b0;
            io3Oe      <= 1'b0;
            quadMode   <= 1'b0;
            holdActive <= 1'b0;
        end else begin
            io2Out     <= coreIo2Out & quadEnable;  // R18
            io2Oe      <= coreIo2Oe & quadEnable;   // R18
            io3Out     <= coreIo3Out & quadEnable;  // R18
            io3Oe      <= coreIo3Oe & quadEnable;   // R18
            quadMode   <= quadEnable;
            holdActive <= pinHold;
        end
    end

    // Frame capture: shift on rising edge, status out on falling edge
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state       <= ST_IDLE;
            sclkPrev    <= 1'b0;
            csPrev      <= 1'b1;
            bitCnt      <= 8'h00;
            shiftIn     <= 8'h00;
            opReg       <= 8'h00;
            dataReg     <= 8'h00;
            addrReg     <= 24'h000000;
            statusShift <= `SR_RESET;
            outCnt      <= 3'h0;
            soOut       <= 1'b0;
            soOe        <= 1'b0;
        end else begin
            csPrev <= csN;
            // Hold freezes the clock view so the frame resumes intact
            if (!pinHold) begin
                sclkPrev <= sclk;
            end
            if (csN || pinReset) begin
                state <= ST_IDLE;
                soOe  <= 1'b0;
            end else if (!pinHold) begin
                case (state)
                    ST_IDLE: begin
                        state   <= ST_SHIFT;
                        bitCnt  <= 8'h00;
                        opReg   <= 8'h00;
                        shiftIn <= 8'h00;
                    end
                    ST_SHIFT: begin
                        if (sclkRise) begin
                            shiftIn <= opNow;
                            if (bitCnt != `CNT_MAX) begin
                                bitCnt <= bitCnt + 8'h01;
                            end
                            if (bitCnt == `CNT_BYTE1_LAST) begin
                                dataReg <= opNow;
                            end
                            // Address shifts in MSB first over the 24 bits after the opcode
                            if (bitCnt > `CNT_OPC_LAST) begin
                                if (bitCnt <= `CNT_ADDR_LAST) begin
                                    // One shift per bit, so the last bit needs no special case
                                    addrReg <= {addrReg[22:0], si};
                                end
                            end
                            if (bitCnt == `CNT_OPC_LAST) begin
                                opReg <= opNow;
                                if (busy && !allowedBusy(opNow, busyArray)) begin
                                    state <= ST_SKIP; // R3
                                end else if (opNow == `OPC_READ_STATUS) begin
                                    state       <= ST_STATUS; // R12 R21
                                    statusShift <= statusNow;
                                    outCnt      <= 3'h0;
                                end
                            end
                        end
                    end
                    ST_STATUS: begin
                        // Whole byte repeats with fresh contents while selected
                        if (sclkFall) begin
                            soOe   <= 1'b1;
                            soOut  <= statusShift[7]; // R20
                            outCnt <= outCnt + 3'h1;
                            if (outCnt == `OUT_BIT_LAST) begin
                                statusShift <= statusNow; // R12
                            end else begin
                                statusShift <= {statusShift[6:0], 1'b0};
                            end
                        end
                    end
                    default: begin
                        state <= ST_SKIP; // R3
                    end
                endcase
            end
        end
    end

    // Instruction execution at the end of the frame
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy              <= 1'b0;
            busyArray         <= 1'b0;
            write_enable_latch               <= 1'b0;
            protectLevel      <= `BP_RESET;
            quadEnable        <= 1'b0;
            statusLock        <= 1'b0;
            protectFromBottom <= 1'b0;
            resetArmed        <= 1'b0;
            nvStart           <= 1'b0;
            opStart           <= 1'b0;
            opCode            <= 8'h00;
            opAddr            <= 24'h000000;
            suspendReq        <= 1'b0;
            abortReq          <= 1'b0;
        end else begin
            nvStart    <= 1'b0;
            opStart    <= 1'b0;
            suspendReq <= 1'b0;
            abortReq   <= 1'b0;
            // Completion wins over nothing else started in the same cycle
            if (busy && (busyArray ? opDone : nvDone)) begin
                busy      <= 1'b0; // R4
                busyArray <= 1'b0;
                write_enable_latch       <= 1'b0; // R5
            end
            if (pinReset) begin
                // Hardware reset aborts work; data in flight may be lost
                busy       <= 1'b0;
                busyArray  <= 1'b0;
                write_enable_latch        <= 1'b0;
                resetArmed <= 1'b0;
                abortReq   <= busy;
            end else if (csRise && state == ST_SHIFT && bitCnt >= `CNT_OPC) begin
                resetArmed <= (opReg == `OPC_RESET_ENA) && (bitCnt == `CNT_OPC);
                if (opReg == `OPC_RESET_GO) begin
                    if (resetArmed) begin
                        busy      <= 1'b0; // R3
                        busyArray <= 1'b0;
                        write_enable_latch       <= 1'b0;
                        abortReq  <= 1'b1;
                    end
                end else if (busy) begin
                    if ((opReg == `OPC_SUSPEND_A) || (opReg == `OPC_SUSPEND_B)) begin
                        suspendReq <= busyArray; // R3
                    end
                end else if (opReg == `OPC_SET_WEL) begin
                    write_enable_latch <= 1'b1; // R5 R21
                end else if (opReg == `OPC_CLR_WEL) begin
                    write_enable_latch <= 1'b0; // R5 R21
                end else if (opReg == `OPC_WRITE_STATUS) begin
                    // Latch bit of the data byte is dropped
                    if (write_enable_latch && !hwLocked && bitCnt >= `CNT_BYTE1) begin // R9 R16 R17 R22
                        statusLock   <= dataReg[`SR_LOCK];                // R11
                        quadEnable   <= dataReg[`SR_QE];                  // R11
                        protectLevel <= dataReg[`SR_BP_MSB:`SR_BP_LSB];   // R11 R6
                        busy         <= 1'b1;                             // R2
                        nvStart      <= 1'b1;
                    end
                end else if (opReg == `OPC_WRITE_FUNC) begin
                    if (write_enable_latch && bitCnt >= `CNT_BYTE1) begin // R9 R22
                        // One-time bit: can be set, never cleared
                        protectFromBottom <= protectFromBottom
                            | dataReg[`FUNC_BOTTOM_BIT]; // R19
                        busy    <= 1'b1; // R2
                        nvStart <= 1'b1;
                        opStart <= 1'b1;
                        opCode  <= opReg;
                    end
                end else if ((opReg == `OPC_READ_NV) || (opReg == `OPC_EXT_READ_NV)
                        || (opReg == `OPC_AUTOBOOT)) begin
                    if (write_enable_latch && bitCnt >= `CNT_BYTE1) begin // R9 R22
                        busy    <= 1'b1; // R2
                        nvStart <= 1'b1;
                        opStart <= 1'b1;
                        opCode  <= opReg;
                    end
                end else if ((opReg == `OPC_CHIP_ERASE_A) || (opReg == `OPC_CHIP_ERASE_B)) begin
                    if (write_enable_latch && protectLevel == `BP_RESET && bitCnt == `CNT_OPC) begin // R8 R15
                        busy      <= 1'b1; // R2
                        busyArray <= 1'b1;
                        opStart   <= 1'b1;
                        opCode    <= opReg;
                    end
                end else if (isArrayOp(opReg)) begin
                    // Info row work lies outside the main array blocks
                    if (write_enable_latch && bitCnt >= `CNT_ADDR && ((opReg == `OPC_INFO_ERASE)
                            || (opReg == `OPC_INFO_PROG) || !targetProtected)) begin // R7 R8 R9 R14 R22
                        busy      <= 1'b1; // R2
                        busyArray <= 1'b1;
                        opStart   <= 1'b1;
                        opCode    <= opReg;
                        opAddr    <= addrReg;
                    end
                end
                // Volatile parameter sets fall through untouched, latch not needed R10
            end
        end
    end
endmodule // flash_status_write_protect

// ### design/flash_status_consts.vh
// Constants for the status register and write-protection block
`ifndef FLASH_STATUS_CONSTS_VH
`define FLASH_STATUS_CONSTS_VH

// Status register layout and reset value
`define SR_BUSY          0
`define SR_WEL           1
`define SR_BP_LSB        2
`define SR_BP_MSB        5
`define SR_QE            6
`define SR_LOCK          7
`define SR_RESET         8'h00
`define BP_RESET         4'h0
`define BP_ALL_BIT       3

// Instruction codes
`define OPC_READ_STATUS  8'h05
`define OPC_SET_WEL      8'h06
`define OPC_CLR_WEL      8'h04
`define OPC_WRITE_STATUS 8'h01
`define OPC_PAGE_PROG    8'h02
`define OPC_QPROG_A      8'h32
`define OPC_QPROG_B      8'h38
`define OPC_SECT_ERASE_A 8'hD7
`define OPC_SECT_ERASE_B 8'h20
`define OPC_ERASE_32K    8'h52
`define OPC_ERASE_64K    8'hD8
`define OPC_CHIP_ERASE_A 8'hC7
`define OPC_CHIP_ERASE_B 8'h60
`define OPC_INFO_ERASE   8'h64
`define OPC_WRITE_FUNC   8'h42
`define OPC_READ_NV      8'h65
`define OPC_EXT_READ_NV  8'h85
`define OPC_INFO_PROG    8'h62
`define OPC_AUTOBOOT     8'h15
`define OPC_READ_FUNC    8'h48
`define OPC_READ_EXTREG  8'h81
`define OPC_RESET_ENA    8'h66
`define OPC_RESET_GO     8'h99
`define OPC_SUSPEND_A    8'h75
`define OPC_SUSPEND_B    8'hB0

// Frame bit counts at which fields are complete
`define CNT_OPC          8'h08
`define CNT_BYTE1        8'h10
`define CNT_ADDR         8'h20
`define CNT_MAX          8'hFF
`define CNT_OPC_LAST     8'h07
`define CNT_BYTE1_LAST   8'h0F
`define CNT_ADDR_LAST    8'h1F
`define OUT_BIT_LAST     3'h7

// Address fields
`define ADDR_BLK_MSB     22
`define ADDR_BLK_LSB     16
`define FUNC_BOTTOM_BIT  1
`define BLOCK_COUNT      8'h80

// Non-volatile register write time
`define CLK_PERIOD_NS    100
`define NV_WRITE_TIME_NS 50000
`define NV_WRITE_CYCLES  ((`NV_WRITE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIMER_W          12

`endif

// ### design/protect_decoder.v
// Maps protect level and top/bottom selection to a per-block protection flag
`timescale 1ns/1ps
`include "flash_status_consts.vh"

module protect_decoder (
    input  wire [3:0] protectLevel,
    input  wire       fromBottom,
    input  wire [6:0] blockNum,
    output reg        blockProtected
);
    // Number of protected blocks for a level below eight
    function [7:0] span;
        input [2:0] lvl;
        begin
            span = (lvl == 3'h0) ? 8'h00 : (8'h01 << (lvl - 3'h1));
        end
    endfunction

    reg [7:0] count;

    // Top counts down from the last block, bottom up from block zero
    always @* begin
        count = span(protectLevel[2:0]);
        if (protectLevel[`BP_ALL_BIT]) begin
            blockProtected = 1'b1; // R14
        end else if (count == 8'h00) begin
            blockProtected = 1'b0; // R14
        end else if (fromBottom) begin
            blockProtected = ({1'b0, blockNum} < count); // R13
        end else begin
            blockProtected = ({1'b0, blockNum} >= (`BLOCK_COUNT - count)); // R13
        end
    end
endmodule // protect_decoder

// ### design/nv_write_timer.v
// Counts out the busy time of a non-volatile register write
`timescale 1ns/1ps
`include "flash_status_consts.vh"

module nv_write_timer (
    input  wire ref_clk,
    input  wire arst_n,
    input  wire start,
    input  wire abort,
    output reg  done
);
    localparam integer        LAST_INT = `NV_WRITE_CYCLES - 1;
    localparam [`TIMER_W-1:0] LAST     = LAST_INT[`TIMER_W-1:0];

    reg [`TIMER_W-1:0] count;
    reg                running;

    // One-cycle done pulse after the full write time
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            count   <= {`TIMER_W{1'b0}};
            running <= 1'b0;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            if (abort) begin
                running <= 1'b0;
            end else if (start) begin
                count   <= {`TIMER_W{1'b0}};
                running <= 1'b1;
            end else if (running) begin
                if (count == LAST) begin
                    running <= 1'b0;
                    done    <= 1'b1;
                end else begin
                    count <= count + 1'b1;
                end
            end
        end
    end
endmodule // nv_write_timer

// ### tb/flash_status_write_protect_props.sv
// Assertion checker for the flash status and write-protect block
`timescale 1ns/1ps
module flash_status_write_protect_props (
    input wire logic       ref_clk,
    input wire logic       arst_n,
    input wire logic       csN,
    input wire logic       sclk,
    input wire logic       soOut,
    input wire logic       soOe,
    input wire logic       coreIo2Out,
    input wire logic       coreIo2Oe,
    input wire logic       io2Out,
    input wire logic       io2Oe,
    input wire logic       io3Oe,
    input wire logic       opStart,
    input wire logic [7:0] opCode,
    input wire logic       quadMode,
    input wire logic       protectFromBottom
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // Launches are single pulses, only once the frame has closed
    a_start_pulse: assert property (opStart |=> !opStart)
        else $error("launch longer than a cycle");
    a_start_framed: assert property (opStart |-> csN && $past(csN))
        else $error("launch inside a frame");
    // Only gated program, erase and register writes may launch work
    a_start_code: assert property (opStart |-> opCode inside {8'h02, 8'h32, 8'h38, 8'hD7,
        8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60, 8'h64, 8'h62, 8'h01, 8'h42, 8'h65, 8'h85, 8'h15})
        else $error("unexpected launch code");
    // Status output let go once select has been high a while
    a_so_release: assert property (csN [*3] |-> !soOe)
        else $error("output enable held");
    // Output bit moves only after a serial clock fall
    a_so_steady: assert property (sclk && $past(sclk) |-> $stable(soOut))
        else $error("output moved while clock high");
    // Extra pins are inputs with quad off; pin 2 follows the core with it on
    a_quad_off: assert property (!quadMode && !$past(quadMode) |-> !io2Oe && !io3Oe)
        else $error("pin driven with quad off");
    a_quad_follow: assert property (quadMode && $past(quadMode) |->
        io2Oe == $past(coreIo2Oe) && io2Out == $past(coreIo2Out))
        else $error("pin 2 not following core");
    // One-time bottom selection and persistent bits
    a_bottom_keep: assert property (protectFromBottom |=> protectFromBottom)
        else $error("bottom selection reverted");
    a_nv_at_frame: assert property ($changed(quadMode) |-> csN)
        else $error("quad bit moved inside frame");
    c_launch: cover property (opStart);
    c_quad: cover property ($rose(quadMode));
    c_bottom: cover property ($rose(protectFromBottom));
endmodule // flash_status_write_protect_props

bind flash_status_write_protect flash_status_write_protect_props u_props (.ref_clk, .arst_n,
    .csN, .sclk, .soOut, .soOe, .coreIo2Out, .coreIo2Oe, .io2Out, .io2Oe, .io3Oe, .opStart,
    .opCode, .quadMode, .protectFromBottom);

// ### tb/flash_host_model.sv
// Host serial controller model that frames instructions for the flash block
`timescale 1ns/1ps
module flash_host_model (
    input  wire logic ref_clk,
    input  wire logic soOut,
    output logic      sclk,
    output logic      csN,
    output logic      si
);
    // Mode 0 idle: clock low, deselected
    initial begin
        sclk = 1'b0;
        csN = 1'b1;
        si = 1'b0;
    end
    // One bit: data moves with clock low, read back just before the rise
    task automatic bitx(input logic b, output logic r);
        sclk <= 1'b0;
        si <= b;
        repeat (4) @(posedge ref_clk);
        r = soOut;
        sclk <= 1'b1;
        repeat (2) @(posedge ref_clk);
    endtask
    // Opcode and fields MSB first, then read bits; idle data toggles
    task automatic frame(input logic [31:0] tx, input int nTx, input int nRx,
                         output logic [7:0] rx);
        logic r;
        rx = 8'h00;
        csN <= 1'b0;
        @(posedge ref_clk);
        for (int i = 0; i < nTx; i++) bitx(tx[31 - i], r);
        for (int i = 0; i < nRx; i++) begin
            bitx(~si, r);
            rx[7 - i] = r;
        end
        sclk <= 1'b0;
        @(posedge ref_clk);
        csN <= 1'b1;
        si <= ~si;
        repeat (4) @(posedge ref_clk);
    endtask
endmodule // flash_host_model

// ### tb/flash_status_write_protect_test.sv
// Self-checking bench for the flash status and write-protect block
`timescale 1ns/1ps
`include "flash_status_consts.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
    $display("CHECK FAILED at %0t: got %0h expected %0h", $time, g, e); end end
module flash_status_write_protect_test;
    logic        ref_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        io2In = 1'b1;
    logic        opDone = 1'b0;
    logic        coreIo2Out = 1'b0;
    logic        coreIo2Oe = 1'b0;
    logic        sclk, csN, si, soOut, io2Out, io2Oe, opStart, quadMode, protectFromBottom;
    logic [7:0]  opCode, lastCode;
    logic [23:0] opAddr, lastAddr;
    int          fails = 0;
    int          n_compared = 0;
    int          starts = 0;
    logic [7:0]  arrOps [11] = '{`OPC_PAGE_PROG, `OPC_QPROG_A, `OPC_QPROG_B, `OPC_SECT_ERASE_A,
        `OPC_SECT_ERASE_B, `OPC_ERASE_32K, `OPC_ERASE_64K, `OPC_INFO_ERASE, `OPC_INFO_PROG,
        `OPC_CHIP_ERASE_A, `OPC_CHIP_ERASE_B};
    logic [7:0]  regOps [5] = '{`OPC_WRITE_STATUS, `OPC_WRITE_FUNC, `OPC_READ_NV,
        `OPC_EXT_READ_NV, `OPC_AUTOBOOT};

    always #50 ref_clk = ~ref_clk;

    flash_status_write_protect dut (.ref_clk, .arst_n, .sclk, .csN, .si, .io2In, .io3In(1'b1),
        .resetPinSelect(1'b0), .opDone, .coreIo2Out, .coreIo2Oe, .coreIo3Out(1'b0),
        .coreIo3Oe(1'b0), .soOut, .soOe(), .io2Out, .io2Oe, .io3Out(), .io3Oe(), .opStart,
        .opCode, .opAddr, .suspendReq(), .abortReq(), .quadMode, .holdActive(),
        .protectFromBottom);
    flash_host_model host (.ref_clk, .soOut, .sclk, .csN, .si);

    // Record launches so refused instructions can be told apart
    always @(posedge ref_clk) begin
        if (opStart === 1'b1) begin
            starts++;
            lastCode = opCode;
            lastAddr = opAddr;
        end
    end

    task automatic send(input logic [31:0] bits, input int n);
        logic [7:0] rx;
        host.frame(bits, n, 0, rx);
    endtask
    task automatic read_status_cmd(input logic [7:0] e);
        logic [7:0] rx;
        host.frame({`OPC_READ_STATUS, 24'h000000}, 8, 8, rx);
        `CHK(rx, e)
    endtask
    // Poll busy with a bounded number of reads
    task automatic waitIdle;
        logic [7:0] rx;
        rx = 8'h01;
        for (int i = 0; i < 30 && rx[0] !== 1'b0; i++)
            host.frame({`OPC_READ_STATUS, 24'h000000}, 8, 8, rx);
        `CHK(rx[0], 1'b0)
    endtask
    task automatic setWel;
        send({`OPC_SET_WEL, 24'h000000}, 8);
    endtask
    task automatic wrReg(input logic [7:0] opc, input logic [7:0] d);
        send({opc, d, 16'h0000}, 16);
        waitIdle;
    endtask
    // Launch expected or refused; a launch is finished by pulsing opDone
    task automatic tryOp(input logic [7:0] opc, input logic [23:0] a, input int n, input int go);
        int s;
        s = starts;
        send({opc, a}, n);
        repeat (2) @(posedge ref_clk);
        `CHK(starts - s, go)
        if (go) begin
            `CHK(lastCode, opc)
            if (n == 32) `CHK(lastAddr, a)
            opDone <= 1'b1;
            @(posedge ref_clk);
            opDone <= 1'b0;
            waitIdle;
        end
    endtask

    task automatic finish_test;
        if (fails == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Watchdog well beyond the expected run
    initial begin
        repeat (60000) @(posedge ref_clk);
        fails++;
        finish_test;
    end

    initial begin
        repeat (10) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        read_status_cmd(8'h00);
        foreach (arrOps[i]) tryOp(arrOps[i], 24'h010000, i < 9 ? 32 : 8, 0);
        foreach (regOps[i]) tryOp(regOps[i], 24'h000000, 16, 0);
        read_status_cmd(8'h00);
        setWel;
        read_status_cmd(8'h02);
        send({`OPC_CLR_WEL, 24'h000000}, 8);
        read_status_cmd(8'h00);
        setWel;
        send({`OPC_WRITE_STATUS, 24'h8C0000}, 16);
        read_status_cmd(8'h8F);
        send({`OPC_CLR_WEL, 24'h000000}, 8);
        read_status_cmd(8'h8F);
        waitIdle;
        read_status_cmd(8'h8C);
        setWel;
        tryOp(`OPC_SECT_ERASE_B, 24'h7C0000, 32, 0);
        tryOp(`OPC_CHIP_ERASE_A, 24'h000000, 8, 0);
        tryOp(`OPC_SECT_ERASE_B, 24'h7B0000, 32, 1);
        read_status_cmd(8'h8C);
        io2In <= 1'b0;
        setWel;
        wrReg(`OPC_WRITE_STATUS, 8'h00);
        read_status_cmd(8'h8E);
        io2In <= 1'b1;
        wrReg(`OPC_WRITE_STATUS, 8'h00);
        read_status_cmd(8'h00);
        foreach (arrOps[i]) begin
            setWel;
            tryOp(arrOps[i], 24'h010000, i < 9 ? 32 : 8, 1);
        end
        setWel;
        wrReg(`OPC_WRITE_FUNC, 8'h02);
        `CHK(protectFromBottom, 1'b1)
        setWel;
        wrReg(`OPC_WRITE_STATUS, 8'h04);
        setWel;
        tryOp(`OPC_SECT_ERASE_B, 24'h000000, 32, 0);
        tryOp(`OPC_SECT_ERASE_B, 24'h7F0000, 32, 1);
        setWel;
        wrReg(`OPC_WRITE_FUNC, 8'h00);
        `CHK(protectFromBottom, 1'b1)
        setWel;
        wrReg(`OPC_WRITE_STATUS, 8'h40);
        `CHK(quadMode, 1'b1)
        coreIo2Oe <= 1'b1;
        coreIo2Out <= 1'b1;
        repeat (2) @(posedge ref_clk);
        `CHK({io2Oe, io2Out}, 2'b11)
        finish_test;
    end
endmodule // flash_status_write_protect_test
